// *** hdl/dag_core.sv ***
// How it works
// RULE1: seven modes: immediate, pointer, pointer+index, base+disp, direct, table, external.
// RULE2: immediate operand comes from the instruction as byte or word.
// RULE3: immediate word load places the word into B:accumulator at once.
// RULE4: pointer mode picks one of 64 pointers; its content is the address.
// RULE5: each pointer is two RAM bytes, low byte at the lower address.
// RULE6: pointer plus sign-extended index register forms the address.
// RULE7: pointer zero plus signed 7-bit displacement forms the address.
// RULE8: data space splits into reserved, special-function and RAM/stack areas.
// RULE9: indexed read leaving the base area returns FF.
// RULE10: base in special-function area keeps low sum byte over FE00.
// RULE11: FE00, FE01, FE02 decode to accumulator, B and index register.
// RULE12: direct address from operand, short 2-byte and long 3-byte forms.
// RULE13: decrement-and-branch decrements the byte, branches when zero.
// RULE14: compare-and-branch compares immediate with accumulator, accumulator kept.
// RULE15: pointers live at RAM 0 to 7E, usable as plain RAM otherwise.
// RULE16: push increments the stack pointer first; pop reads then decrements.
// RULE17: indexed write leaving the base area is suppressed.
module dag_core
    import dag_pkg::*;
(
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // decoder request
    input  wire logic        i_op_valid,
    input  dag_mode_e        i_mode,
    input  dag_op_e          i_op,
    input  wire logic [5:0]  i_ptr_sel,
    input  wire logic [6:0]  i_disp,
    input  wire logic [15:0] i_imm,
    input  wire logic [15:0] i_dir_addr,
    input  wire logic        i_dir_long,
    // decoder answer
    output logic             o_busy,
    output logic             o_done,
    output logic             o_branch,
    output logic      [1:0]  o_instr_len,
    // data memory port
    output logic      [15:0] o_mem_addr,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic      [7:0]  o_mem_wdata,
    input  wire logic [7:0]  i_mem_rdata,
    // table and external requests
    output logic             o_tbl_req,
    output logic             o_ext_req,
    output logic      [23:0] o_far_addr,
    // register view
    output logic      [7:0]  o_acc,
    output logic      [7:0]  o_breg,
    output logic      [7:0]  o_creg,
    output logic      [15:0] o_sp
);

    typedef enum logic [3:0] {
        S_IDLE, S_PLO, S_PHI, S_PWT, S_CALC, S_RD, S_RDW1, S_RDW2, S_WR, S_DONE
    } dag_state_e;

    dag_state_e  state_q, state_d;
    dag_mode_e   mode_q, mode_d;
    dag_op_e     op_q, op_d;
    logic [5:0]  sel_q, sel_d;
    logic [6:0]  disp_q, disp_d;
    logic [15:0] base_q, base_d, eff_q, eff_d, acc_addr_q, acc_addr_d;
    logic        oob_q, oob_d, chk_q, chk_d, step_q, step_d;
    logic [7:0]  data_q, data_d, acc_q, acc_d, b_q, b_d, c_q, c_d;
    logic [15:0] sp_q, sp_d, mem_addr_q, mem_addr_d;
    logic        busy_q, done_q, done_d, branch_q, branch_d, rd_q, rd_d, wr_q, wr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic [1:0]  len_q, len_d;
    logic        tbl_q, tbl_d, ext_q, ext_d;
    logic [23:0] far_q, far_d;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic [15:0] ptr_lo   = {9'h000, sel_q, 1'b0}; // [RULE5] [RULE15]
    wire logic [15:0] idx_ext  = {{8{c_q[7]}}, c_q}; // [RULE6]
    wire logic [15:0] disp_ext = {{9{disp_q[6]}}, disp_q}; // [RULE7]
    wire logic [15:0] off_sel  = (mode_q == MODE_DISP) ? disp_ext : idx_ext;
    wire logic        use_off  = (mode_q == MODE_PTR_IDX) || (mode_q == MODE_DISP);
    wire logic [15:0] calc_addr;
    wire logic        calc_oob;
    // short direct form: bit 8 selects the sfr page, low byte the location
    wire logic [15:0] dir_short = i_dir_addr[8] ? {SFR_PAGE, i_dir_addr[7:0]}
                                                : {8'h00, i_dir_addr[7:0]};
    wire logic [15:0] dir_addr  = i_dir_long ? i_dir_addr : dir_short; // [RULE12]

    wire logic hit_a    = (acc_addr_q == SFR_ACC); // [RULE11]
    wire logic hit_b    = (acc_addr_q == SFR_BREG);
    wire logic hit_c    = (acc_addr_q == SFR_CREG);
    wire logic hit_int  = hit_a || hit_b || hit_c;
    wire logic blocked  = chk_q && oob_q;
    wire logic need_mem = !hit_int && !blocked;
    wire logic [7:0] int_val = hit_a ? acc_q : (hit_b ? b_q : c_q);
    // out-of-area reads never reach memory and read as FF
    wire logic [7:0] rd_val  = blocked ? OOB_READ : (hit_int ? int_val : i_mem_rdata); // [RULE9]
    wire logic [7:0] dec_val = rd_val - BYTE_ONE;
    wire logic [15:0] sp_inc = sp_q + ADDR_STEP;
    wire logic [15:0] sp_dec = sp_q - ADDR_STEP;
    wire logic [15:0] eff_nx = eff_q + ADDR_STEP;

    dag_area_calc u_area (
        .i_base        (base_q),
        .i_offset      (off_sel),
        .i_use_offset  (use_off),
        .o_addr        (calc_addr),
        .o_out_of_area (calc_oob)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;   mode_d = mode_q;   op_d = op_q;     sel_d = sel_q;
        disp_d = disp_q;     base_d = base_q;   eff_d = eff_q;   acc_addr_d = acc_addr_q;
        oob_d = oob_q;       chk_d = chk_q;     step_d = step_q; data_d = data_q;
        acc_d = acc_q;       b_d = b_q;         c_d = c_q;       sp_d = sp_q;
        mem_addr_d = mem_addr_q;  wdata_d = wdata_q;  len_d = len_q;  far_d = far_q;
        done_d = 1'b0;  branch_d = branch_q;  rd_d = 1'b0;  wr_d = 1'b0;
        tbl_d = 1'b0;   ext_d = 1'b0;
        unique case (state_q)
            S_IDLE: if (i_op_valid) begin
                mode_d = i_mode;  op_d = i_op;  disp_d = i_disp;  step_d = 1'b0;
                chk_d = 1'b0;     oob_d = 1'b0; branch_d = 1'b0;
                sel_d = (i_mode == MODE_DISP) ? PTR_ZERO : i_ptr_sel; // [RULE7]
                len_d = i_dir_long ? LEN_LONG : LEN_SHORT;
                unique case (i_mode)
                    MODE_IMM: begin // [RULE2]
                        state_d = S_DONE;
                        done_d = 1'b1;
                        if (i_op == OP_LD) acc_d = i_imm[7:0];
                        if (i_op == OP_LOAD_WORD) {b_d, acc_d} = i_imm; // [RULE3]
                        if (i_op == OP_CMP_BRANCH_EQUAL) branch_d = (i_imm[7:0] == acc_q); // [RULE14]
                        if (i_op == OP_PUSH) begin
                            sp_d = sp_inc; // [RULE16]
                            acc_addr_d = sp_inc;
                            data_d = i_imm[7:0];
                            state_d = S_WR;
                            done_d = 1'b0;
                        end
                    end
                    MODE_DIRECT: begin
                        base_d = dir_addr; // [RULE12]
                        state_d = S_CALC;
                    end
                    default: begin // [RULE4]
                        state_d = S_PLO;
                        rd_d = 1'b1;
                        mem_addr_d = {9'h000, (i_mode == MODE_DISP) ? PTR_ZERO : i_ptr_sel, 1'b0};
                    end
                endcase
            end
            S_PLO: begin
                rd_d = 1'b1;
                mem_addr_d = ptr_lo + ADDR_STEP; // [RULE5]
                state_d = S_PHI;
            end
            S_PHI: begin
                base_d[7:0] = i_mem_rdata;
                state_d = S_PWT;
            end
            S_PWT: begin
                base_d[15:8] = i_mem_rdata;
                state_d = S_CALC;
            end
            S_CALC: begin // [RULE1]
                eff_d = calc_addr;
                oob_d = calc_oob;
                acc_addr_d = calc_addr;
                chk_d = 1'b1;
                state_d = S_RD;
                unique case (op_q)
                    OP_ST, OP_STORE_WORD: begin
                        data_d = acc_q;
                        state_d = S_WR;
                    end
                    OP_POP: begin
                        acc_addr_d = sp_q; // [RULE16]
                        chk_d = 1'b0;
                    end
                    OP_CMP_BRANCH_EQUAL: state_d = S_DONE;
                    default: ;
                endcase
                if (mode_q == MODE_TABLE || mode_q == MODE_EXT) begin
                    tbl_d = (mode_q == MODE_TABLE);
                    ext_d = (mode_q == MODE_EXT);
                    far_d = {(mode_q == MODE_EXT) ? b_q : 8'h00, calc_addr};
                    state_d = S_DONE;
                end
                done_d = (state_d == S_DONE);
            end
            S_RD: begin
                rd_d = need_mem;
                mem_addr_d = acc_addr_q;
                state_d = S_RDW1;
            end
            S_RDW1: state_d = S_RDW2;
            S_RDW2: begin
                state_d = S_DONE;
                done_d = 1'b1;
                unique case (op_q)
                    OP_LD: acc_d = rd_val;
                    OP_LOAD_WORD: begin
                        if (step_q) b_d = rd_val;
                        else begin
                            acc_d = rd_val;
                            step_d = 1'b1;
                            acc_addr_d = eff_nx;
                            state_d = S_RD;
                            done_d = 1'b0;
                        end
                    end
                    OP_PUSH: begin
                        sp_d = sp_inc; // [RULE16]
                        acc_addr_d = sp_inc;
                        chk_d = 1'b0;
                        data_d = rd_val;
                        state_d = S_WR;
                        done_d = 1'b0;
                    end
                    OP_POP: begin
                        sp_d = sp_dec; // [RULE16]
                        acc_addr_d = eff_q;
                        chk_d = 1'b1;
                        data_d = rd_val;
                        state_d = S_WR;
                        done_d = 1'b0;
                    end
                    OP_DEC_BRANCH_ZERO: begin
                        data_d = dec_val; // [RULE13]
                        branch_d = (dec_val == 8'h00);
                        state_d = S_WR;
                        done_d = 1'b0;
                    end
                    default: ;
                endcase
            end
            S_WR: begin
                wr_d = need_mem; // [RULE17]
                mem_addr_d = acc_addr_q;
                wdata_d = data_q;
                if (!blocked && hit_a) acc_d = data_q; // [RULE11]
                if (!blocked && hit_b) b_d = data_q;
                if (!blocked && hit_c) c_d = data_q;
                state_d = S_DONE;
                done_d = 1'b1;
                if (op_q == OP_STORE_WORD && !step_q) begin
                    step_d = 1'b1;
                    acc_addr_d = eff_nx;
                    data_d = b_q;
                    state_d = S_WR;
                    done_d = 1'b0;
                end
            end
            S_DONE: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= S_IDLE;  mode_q <= MODE_IMM;  op_q <= OP_LD;  sel_q <= PTR_ZERO;
            disp_q <= 7'h00;    base_q <= RST_WORD;  eff_q <= RST_WORD;
            acc_addr_q <= RST_WORD;  oob_q <= 1'b0;  chk_q <= 1'b0;  step_q <= 1'b0;
            data_q <= RST_BYTE; acc_q <= RST_BYTE;   b_q <= RST_BYTE;  c_q <= RST_BYTE;
            sp_q <= RST_WORD;   mem_addr_q <= RST_WORD;  wdata_q <= RST_BYTE;
            busy_q <= 1'b0;     done_q <= 1'b0;  branch_q <= 1'b0;  rd_q <= 1'b0;
            wr_q <= 1'b0;       len_q <= LEN_SHORT;  tbl_q <= 1'b0;  ext_q <= 1'b0;
            far_q <= 24'h000000;
        end else begin
            state_q <= state_d;  mode_q <= mode_d;  op_q <= op_d;  sel_q <= sel_d;
            disp_q <= disp_d;    base_q <= base_d;  eff_q <= eff_d;
            acc_addr_q <= acc_addr_d;  oob_q <= oob_d;  chk_q <= chk_d;  step_q <= step_d;
            data_q <= data_d;    acc_q <= acc_d;    b_q <= b_d;    c_q <= c_d;
            sp_q <= sp_d;        mem_addr_q <= mem_addr_d;  wdata_q <= wdata_d;
            busy_q <= (state_d != S_IDLE);  done_q <= done_d;  branch_q <= branch_d;
            rd_q <= rd_d;        wr_q <= wr_d;  len_q <= len_d;  tbl_q <= tbl_d;
            ext_q <= ext_d;      far_q <= far_d;
        end
    end

    assign o_busy = busy_q;      assign o_done = done_q;      assign o_branch = branch_q;
    assign o_instr_len = len_q;  assign o_mem_addr = mem_addr_q;
    assign o_mem_rd = rd_q;      assign o_mem_wr = wr_q;      assign o_mem_wdata = wdata_q;
    assign o_tbl_req = tbl_q;    assign o_ext_req = ext_q;    assign o_far_addr = far_q;
    assign o_acc = acc_q;        assign o_breg = b_q;         assign o_creg = c_q;
    assign o_sp = sp_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ptr_fetch_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE5]
        state_q == S_PLO |-> o_mem_rd && o_mem_addr == ptr_lo && o_mem_addr <= 16'h007E)
        else $error("pointer low byte fetched from wrong address");
    a_oob_read_ff: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE9]
        state_q == S_RDW2 && blocked && op_q == OP_LD |=> o_acc == OOB_READ)
        else $error("out of area read did not return FF");
    a_oob_write_blk: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE17]
        state_q == S_WR && blocked |=> !o_mem_wr && o_acc == $past(o_acc))
        else $error("out of area write reached storage");
    a_sfr_wrap_page: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE10]
        state_q == S_CALC && base_q[15:8] == SFR_PAGE |=> eff_q[15:8] == SFR_PAGE && !oob_q)
        else $error("sfr based access left the sfr page");
    a_index_sum: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE6]
        state_q == S_CALC && mode_q == MODE_PTR_IDX && base_q <= RAM_END && !calc_oob
        |=> eff_q == $past(base_q) + {{8{$past(c_q[7])}}, $past(c_q)})
        else $error("indexed address is not base plus signed index");
    a_push_pre_inc: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE16]
        state_q == S_WR && op_q == OP_PUSH |-> acc_addr_q == sp_q ##1 o_mem_addr == o_sp)
        else $error("push did not write at the incremented stack pointer");
    a_imm_word_load: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE3]
        state_q == S_IDLE && i_op_valid && i_mode == MODE_IMM && i_op == OP_LOAD_WORD
        |=> {o_breg, o_acc} == $past(i_imm) && o_done)
        else $error("immediate word not placed in B and accumulator");
    a_cmp_acc_kept: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE14]
        state_q == S_IDLE && i_op_valid && i_mode == MODE_IMM && i_op == OP_CMP_BRANCH_EQUAL
        |=> o_acc == $past(o_acc) && o_branch == ($past(i_imm[7:0]) == $past(o_acc)))
        else $error("compare branch wrong or accumulator changed");
    a_dec_branch: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [RULE13]
        state_q == S_RDW2 && op_q == OP_DEC_BRANCH_ZERO
        |=> data_q == $past(rd_val) - 8'h01 && o_branch == (data_q == 8'h00) ##1 o_done)
        else $error("decrement branch result or branch wrong");

endmodule

// *** hdl/dag_pkg.sv ***
package dag_pkg;

    // ------------------------------------------------------------
    // data space areas
    // ------------------------------------------------------------
    localparam logic [15:0] RAM_END      = 16'hFDFF;
    localparam logic [15:0] RSV_START    = 16'hFF00;
    localparam logic [7:0]  SFR_PAGE     = 8'hFE;
    localparam logic [15:0] SFR_ACC      = 16'hFE00;
    localparam logic [15:0] SFR_BREG     = 16'hFE01;
    localparam logic [15:0] SFR_CREG     = 16'hFE02;
    localparam logic [7:0]  OOB_READ     = 8'hFF;

    // ------------------------------------------------------------
    // reset values and small constants
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [15:0] ADDR_STEP    = 16'h0001;
    localparam logic [7:0]  BYTE_ONE     = 8'h01;
    localparam logic [5:0]  PTR_ZERO     = 6'h00;
    localparam logic [1:0]  LEN_SHORT    = 2'h2;
    localparam logic [1:0]  LEN_LONG     = 2'h3;

    // ------------------------------------------------------------
    // modes and operations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_IMM,
        MODE_PTR,
        MODE_PTR_IDX,
        MODE_DISP,
        MODE_DIRECT,
        MODE_TABLE,
        MODE_EXT
    } dag_mode_e;

    typedef enum logic [2:0] {
        OP_LD,
        OP_LOAD_WORD,
        OP_ST,
        OP_STORE_WORD,
        OP_PUSH,
        OP_POP,
        OP_DEC_BRANCH_ZERO,
        OP_CMP_BRANCH_EQUAL
    } dag_op_e;

endpackage

// *** hdl/dag_area_calc.sv ***
module dag_area_calc
    import dag_pkg::*;
(
    // base and offset
    input  wire logic [15:0] i_base,
    input  wire logic [15:0] i_offset,
    input  wire logic        i_use_offset,
    // result
    output logic      [15:0] o_addr,
    output logic             o_out_of_area
);

    wire logic [15:0] sum      = i_base + (i_use_offset ? i_offset : RST_WORD);
    wire logic        base_sfr = (i_base[15:8] == SFR_PAGE);
    wire logic        base_rsv = (i_base >= RSV_START);

    // sfr area is only 8 bits wide, so the carry out is dropped
    assign o_addr        = base_sfr ? {SFR_PAGE, sum[7:0]} : sum; // [RULE10]
    // area is fixed by the base, never by the sum
    assign o_out_of_area = i_use_offset && !base_sfr &&
                           (base_rsv ? (sum < RSV_START) : (sum > RAM_END)); // [RULE8] [RULE9]

endmodule

// *** verification/dag_mem_model.sv ***
module dag_mem_model (
    // memory port from the core
    input  wire logic        i_sys_clk,
    input  wire logic [15:0] i_mem_addr,
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_wr,
    input  wire logic [7:0]  i_mem_wdata,
    // read data back
    output logic      [7:0]  o_mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // pointer pairs share this array at 0..7E
    logic [7:0] ram [0:65535];

    initial o_mem_rdata = 8'h00;

    // ------------------------------------------------------------
    // data valid the cycle after the strobe only
    // ------------------------------------------------------------
    // idle cycles scramble the bus so a late sample never sees a stale byte
    always @(posedge i_sys_clk) begin
        if (i_mem_wr) begin
            ram[i_mem_addr] <= i_mem_wdata;
        end
        if (i_mem_rd) begin
            o_mem_rdata <= ram[i_mem_addr];
        end else begin
            o_mem_rdata <= ~o_mem_rdata;
        end
    end
endmodule

// *** verification/tb.sv ***
module tb
    import dag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        dag_mode_e   mode;
        dag_op_e     op;
        logic [6:0]  sel;
        logic [15:0] opnd;
        logic        lng;
        logic [7:0]  acc;
        logic [7:0]  brg;
        logic [7:0]  crg;
        logic        br;
        logic [1:0]  len;
    } dag_row_s;

    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_op_valid = 1'b0;
    dag_mode_e   i_mode = MODE_IMM;
    dag_op_e     i_op = OP_LD;
    logic [6:0]  sel = 7'h00;
    logic [15:0] opnd = 16'h0000;
    logic        i_dir_long = 1'b0;
    logic        o_busy, o_done, o_branch, o_mem_rd, o_mem_wr, o_tbl_req, o_ext_req;
    logic [1:0]  o_instr_len;
    logic [15:0] o_mem_addr, o_sp;
    logic [7:0]  o_mem_wdata, i_mem_rdata, o_acc, o_breg, o_creg;
    logic [23:0] o_far_addr, far;
    logic        tbl_seen, ext_seen;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;
    int          wr_cnt;

    // expected values follow from the pointer preload in the first initial block
    dag_row_s rows [16] = '{
        '{MODE_IMM,     OP_LD,               7'h00, 16'h0012, 1'h0, 8'h12, 8'h00, 8'h00, 1'h0, 2'h2},
        '{MODE_IMM,     OP_LOAD_WORD,        7'h00, 16'h1234, 1'h0, 8'h34, 8'h12, 8'h00, 1'h0, 2'h2},
        '{MODE_PTR,     OP_LD,               7'h03, 16'h0000, 1'h0, 8'h5A, 8'h12, 8'h00, 1'h0, 2'h2},
        '{MODE_DISP,    OP_LD,               7'h10, 16'h0000, 1'h0, 8'h3C, 8'h12, 8'h00, 1'h0, 2'h2},
        '{MODE_IMM,     OP_LD,               7'h00, 16'h0002, 1'h0, 8'h02, 8'h12, 8'h00, 1'h0, 2'h2},
        '{MODE_DIRECT,  OP_ST,               7'h00, 16'hFE02, 1'h1, 8'h02, 8'h12, 8'h02, 1'h0, 2'h3},
        '{MODE_PTR_IDX, OP_LD,               7'h03, 16'h0000, 1'h0, 8'h77, 8'h12, 8'h02, 1'h0, 2'h2},
        '{MODE_PTR_IDX, OP_LD,               7'h05, 16'h0000, 1'h0, 8'hFF, 8'h12, 8'h02, 1'h0, 2'h2},
        '{MODE_PTR_IDX, OP_LD,               7'h06, 16'h0000, 1'h0, 8'h12, 8'h12, 8'h02, 1'h0, 2'h2},
        '{MODE_PTR,     OP_LD,               7'h07, 16'h0000, 1'h0, 8'h02, 8'h12, 8'h02, 1'h0, 2'h2},
        '{MODE_IMM,     OP_CMP_BRANCH_EQUAL, 7'h00, 16'h0002, 1'h0, 8'h02, 8'h12, 8'h02, 1'h1, 2'h2},
        '{MODE_IMM,     OP_CMP_BRANCH_EQUAL, 7'h00, 16'h0078, 1'h0, 8'h02, 8'h12, 8'h02, 1'h0, 2'h2},
        '{MODE_DIRECT,  OP_LD,               7'h00, 16'h0033, 1'h0, 8'h99, 8'h12, 8'h02, 1'h0, 2'h2},
        '{MODE_DIRECT,  OP_DEC_BRANCH_ZERO,  7'h00, 16'h0200, 1'h1, 8'h99, 8'h12, 8'h02, 1'h1, 2'h3},
        '{MODE_DIRECT,  OP_DEC_BRANCH_ZERO,  7'h00, 16'h0201, 1'h1, 8'h99, 8'h12, 8'h02, 1'h0, 2'h3},
        '{MODE_DISP,    OP_LD,               7'h7E, 16'h0000, 1'h0, 8'h44, 8'h12, 8'h02, 1'h0, 2'h2}
    };

    always #5 i_sys_clk = ~i_sys_clk;

    dag_core dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_mode(i_mode),
        .i_op(i_op), .i_ptr_sel(sel[5:0]), .i_disp(sel), .i_imm(opnd), .i_dir_addr(opnd),
        .i_dir_long(i_dir_long), .o_busy(o_busy), .o_done(o_done), .o_branch(o_branch),
        .o_instr_len(o_instr_len), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
        .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
        .o_tbl_req(o_tbl_req), .o_ext_req(o_ext_req), .o_far_addr(o_far_addr),
        .o_acc(o_acc), .o_breg(o_breg), .o_creg(o_creg), .o_sp(o_sp)
    );

    dag_mem_model u_mem (
        .i_sys_clk(i_sys_clk), .i_mem_addr(o_mem_addr), .i_mem_rd(o_mem_rd),
        .i_mem_wr(o_mem_wr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata)
    );

    task automatic close_out();
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one request, then wait past the done cycle, where a new request would be dropped
    task automatic run_op(input dag_mode_e m, input dag_op_e o, input logic [6:0] s,
                          input logic [15:0] v, input logic l);
        int   n;
        logic got;
        n = 0;
        got = 1'b0;
        wr_cnt = 0;
        tbl_seen = 1'b0;
        ext_seen = 1'b0;
        @(negedge i_sys_clk);
        i_mode = m;
        i_op = o;
        sel = s;
        opnd = v;
        i_dir_long = l;
        i_op_valid = 1'b1;
        while (!got && n < 40) begin
            @(posedge i_sys_clk);
            #1;
            n++;
            got = (o_done === 1'b1);
            if (o_mem_wr === 1'b1) wr_cnt++;
            if (o_tbl_req === 1'b1 || o_ext_req === 1'b1) far = o_far_addr;
            if (o_tbl_req === 1'b1) tbl_seen = 1'b1;
            if (o_ext_req === 1'b1) ext_seen = 1'b1;
            if (n == 1) begin
                @(negedge i_sys_clk);
                i_op_valid = 1'b0;
            end
        end
        check({23'h0, got}, 24'h000001);
        // the last write pulse stands with done and lands on the following edge
        repeat (2) @(negedge i_sys_clk);
    endtask

    task automatic check_idle();
        check({o_acc, o_breg, o_creg}, 24'h000000);
        check({6'h00, o_instr_len, o_sp}, {6'h00, 2'h2, 16'h0000});
        check({21'h0, o_busy, o_done, o_branch}, 24'h000000);
    endtask

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        // pointers 0,3,5,6,7 and the bytes they reach
        {u_mem.ram[1], u_mem.ram[0], u_mem.ram[7], u_mem.ram[6]} = 32'h0123_0123;
        {u_mem.ram[11], u_mem.ram[10], u_mem.ram[13], u_mem.ram[12]} = 32'hFDFF_FEFF;
        {u_mem.ram[15], u_mem.ram[14]} = 16'hFE02;
        u_mem.ram[16'h0123] = 8'h5A;
        u_mem.ram[16'h0133] = 8'h3C;
        u_mem.ram[16'h0125] = 8'h77;
        u_mem.ram[16'h0121] = 8'h44;
        u_mem.ram[16'h0033] = 8'h99;
        u_mem.ram[16'h0200] = 8'h01;
        u_mem.ram[16'h0201] = 8'h05;
        repeat (3) @(negedge i_sys_clk);
        i_rst = 1'b0;
        check_idle();
        foreach (rows[i]) begin
            run_op(rows[i].mode, rows[i].op, rows[i].sel, rows[i].opnd, rows[i].lng);
            check({o_acc, o_breg, o_creg}, {rows[i].acc, rows[i].brg, rows[i].crg});
            check({21'h0, o_branch, o_instr_len}, {21'h0, rows[i].br, rows[i].len});
        end
        check({8'h00, u_mem.ram[16'h0200], u_mem.ram[16'h0201]}, 24'h000004);
        // base FDFF plus index 2 leaves the RAM area: nothing may be written
        run_op(MODE_PTR_IDX, OP_ST, 7'h05, 16'h0000, 1'b0);
        check(wr_cnt[23:0], 24'h000000);
        run_op(MODE_PTR, OP_STORE_WORD, 7'h03, 16'h0000, 1'b0);
        check({wr_cnt[7:0], u_mem.ram[16'h0124], u_mem.ram[16'h0123]}, 24'h021244);
        run_op(MODE_TABLE, OP_LD, 7'h03, 16'h0000, 1'b0);
        check({tbl_seen, far[22:0]}, 24'h800123);
        run_op(MODE_EXT, OP_LD, 7'h03, 16'h0000, 1'b0);
        check({ext_seen, 23'h0}, 24'h800000);
        check(far, 24'h120123);
        run_op(MODE_IMM, OP_PUSH, 7'h00, 16'h0034, 1'b0);
        check({u_mem.ram[1], o_sp}, 24'h340001);
        run_op(MODE_DIRECT, OP_POP, 7'h00, 16'h0300, 1'b1);
        check({u_mem.ram[16'h0300], o_sp}, 24'h340000);
        // second reset in mid-run
        i_rst = 1'b1;
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        check_idle();
        // the core must take a request straight after the mid-run reset
        run_op(MODE_IMM, OP_LOAD_WORD, 7'h00, 16'h1234, 1'b0);
        check({o_acc, o_breg, o_creg}, 24'h341200);
        close_out();
    end
endmodule
